// ===== qulp_pkg.sv
package qulp_pkg;

    // ************************************************
    // register map, byte addresses
    // ************************************************
    localparam logic [4:0] OFF_TXD = 5'h00;
    localparam logic [4:0] OFF_MCR = 5'h04;
    localparam logic [4:0] OFF_EFR = 5'h08;
    localparam logic [4:0] OFF_IER = 5'h0C;
    localparam logic [4:0] OFF_MSR = 5'h10;
    localparam logic [7:0] OFF_STAT = 8'h80;
    localparam logic [7:0] OFF_CLR = 8'h84;
    localparam logic [7:0] OFF_EN = 8'h88;
    localparam logic [7:0] OFF_MODE = 8'h8C;

    // ************************************************
    // field positions
    // ************************************************
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MCR_IRQ = 3;
    localparam int MCR_IR = 6;
    localparam int EFR_ARTS = 6;
    localparam int EFR_ACTS = 7;
    localparam int IER_CTS = 7;

    // ************************************************
    // reset values and counts
    // ************************************************
    localparam logic [7:0] MCR_RST = 8'h00;
    localparam logic [7:0] EFR_RST = 8'h00;
    localparam logic [7:0] IER_RST = 8'h00;
    localparam int BIT_CYC_DEF = 16;
    localparam int FRAME_BITS = 10;

    typedef struct packed {
        logic [7:0] irq_enable_reg;
        logic [7:0] enhanced_feature_reg;
        logic [7:0] modem_control_reg;
    } qulp_ctl_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SEND = 2'b10
    } qulp_tx_st_t;

endpackage

// ===== qulp_chan.sv
`timescale 1ns/100ps
module qulp_chan #(
    parameter int BIT_CYC = qulp_pkg::BIT_CYC_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] tx_byte,
    input wire logic tx_load,
    input wire logic ir_mode,
    input wire logic auto_cts,
    input wire logic cts_n_s,
    output logic pend,
    output logic busy,
    output logic done,
    output logic tx_out
);
    // pulse is 3/16 of a bit, never below one cycle
    localparam int IR_CYC = (BIT_CYC * 3) / 16 < 1 ? 1 : (BIT_CYC * 3) / 16;

    qulp_pkg::qulp_tx_st_t st_r, st_nxt;
    logic [9:0] shift_r;
    logic [15:0] cyc_r;
    logic [3:0] bit_r;
    logic [7:0] hold_r;
    logic pend_r, line_r, done_r;

    // ************************************************
    // transmit control
    // ************************************************
    // hold between characters
    wire hold_off = auto_cts & cts_n_s;
    wire start = (st_r == qulp_pkg::TX_IDLE) & pend_r & ~hold_off;
    wire accept = tx_load & (~pend_r | start);
    wire bit_end = cyc_r == 16'(BIT_CYC - 1);
    wire last = (st_r == qulp_pkg::TX_SEND) & bit_end &
        (bit_r == 4'(qulp_pkg::FRAME_BITS - 1));
    wire ir_hi = ~shift_r[0] & (cyc_r < 16'(IR_CYC));
    wire line_nxt = (st_r == qulp_pkg::TX_SEND) ?
        (ir_mode ? ir_hi : shift_r[0]) : ~ir_mode;

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            qulp_pkg::TX_IDLE: begin
                if (start) begin
                    st_nxt = qulp_pkg::TX_SEND;
                end
            end
            qulp_pkg::TX_SEND: begin
                if (last) begin
                    st_nxt = qulp_pkg::TX_IDLE;
                end
            end
            default: st_nxt = qulp_pkg::TX_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= qulp_pkg::TX_IDLE;
            shift_r <= '1;
            cyc_r <= '0;
            bit_r <= '0;
            hold_r <= '0;
            pend_r <= 1'b0;
            line_r <= 1'b1;
            done_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            shift_r <= start ? {1'b1, hold_r, 1'b0} :
                (bit_end ? {1'b1, shift_r[9:1]} : shift_r);
            cyc_r <= (start | bit_end) ? '0 : cyc_r + 16'h0001;
            bit_r <= start ? '0 : (bit_end ? bit_r + 4'h1 : bit_r);
            hold_r <= accept ? tx_byte : hold_r;
            pend_r <= accept | (pend_r & ~start);
            line_r <= line_nxt;
            done_r <= last;
        end
    end

    assign pend = pend_r;
    assign busy = st_r == qulp_pkg::TX_SEND;
    assign done = done_r;
    assign tx_out = line_r;

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence ir_start;
        $rose(st_r == qulp_pkg::TX_SEND) ##0 ir_mode;
    endsequence

    a_std_idle_high: assert property (
        $past(st_r == qulp_pkg::TX_IDLE && !ir_mode) |-> tx_out)
        else $error("serial idle not high");
    a_ir_idle_low: assert property (
        $past(st_r == qulp_pkg::TX_IDLE && ir_mode) |-> !tx_out)
        else $error("infrared idle not low");
    a_ir_start_pulse: assert property (
        ir_start |=> tx_out [*3] ##1 !tx_out)
        else $error("infrared start pulse wrong");
    a_cts_holds_tx: assert property (
        (st_r == qulp_pkg::TX_IDLE && auto_cts && cts_n_s)
        |=> st_r == qulp_pkg::TX_IDLE)
        else $error("sent while clear-to-send off");
endmodule // qulp_chan

// ===== qulp_top.sv
`timescale 1ns/100ps
// Functional notes
// - strobe mode, select high: all channel irq pins driven always
// - strobe mode, select low: irq pin enabled only while control bit 3 set
// - standard mode: transmit line high in reset and idle
// - control bit 6 routes lines through infrared encoder/decoder
// - infrared mode: low is the idle, no-data level
// - clear-to-send is input or auto gate; its irq gated by enable bit 7
// - request-to-send is general output unless auto flow uses it
// - terminal-ready output driven by software as general output
// - set-ready input is readable only, no effect on transfer
// - strobe mode, select low, bit 3 zero: irq pins high impedance
// - strap high picks strobe bus mode, low read/write-select
module qulp_top #(
    parameter int NCH = 4,
    parameter int BIT_CYC = qulp_pkg::BIT_CYC_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic bus_mode_sel,
    input wire logic irq_output_select,
    input wire logic [NCH-1:0] chan_serial_in,
    output logic [NCH-1:0] chan_serial_out,
    input wire logic [NCH-1:0] chan_clear_send_n,
    output logic [NCH-1:0] chan_request_send_n,
    input wire logic [NCH-1:0] chan_set_ready_n,
    output logic [NCH-1:0] chan_terminal_ready_n,
    input wire logic [NCH-1:0] chan_rx_stop,
    output logic [NCH-1:0] chan_irq_out,
    output logic [NCH-1:0] chan_irq_oe
);
    localparam int SW = 3 * NCH + 2;
    localparam int EW = 2 * NCH;
    localparam logic [SW-1:0] SYNC_RST = {1'b1, 1'b0, {(3 * NCH){1'b1}}};

    // ************************************************
    // pin synchronisers
    // ************************************************
    logic [SW-1:0] s1_r, s2_r;
    logic [NCH-1:0] cts_d_r;
    wire [SW-1:0] s_in = {bus_mode_sel, irq_output_select,
        chan_serial_in, chan_set_ready_n, chan_clear_send_n};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= SYNC_RST;
            s2_r <= SYNC_RST;
            cts_d_r <= '1;
        end else begin
            s1_r <= s_in;
            s2_r <= s1_r;
            cts_d_r <= s2_r[NCH-1:0];
        end
    end

    wire mode_s = s2_r[SW-1];
    wire sel_s = s2_r[SW-2];
    wire [NCH-1:0] rx_s = s2_r[3*NCH-1:2*NCH];
    wire [NCH-1:0] dsr_s = s2_r[2*NCH-1:NCH];
    wire [NCH-1:0] cts_s = s2_r[NCH-1:0];

    // ************************************************
    // apb decode
    // ************************************************
    wire apb_set = psel & ~penable;
    wire apb_wr = psel & penable & pwrite;
    wire [1:0] ch_a = paddr[6:5];
    wire [4:0] reg_a = paddr[4:0];
    wire ch_ok = !paddr[7] && (int'(ch_a) < NCH);
    wire hit_txd = ch_ok && reg_a == qulp_pkg::OFF_TXD;
    wire hit_mcr = ch_ok && reg_a == qulp_pkg::OFF_MCR;
    wire hit_efr = ch_ok && reg_a == qulp_pkg::OFF_EFR;
    wire hit_ier = ch_ok && reg_a == qulp_pkg::OFF_IER;
    wire hit_msr = ch_ok && reg_a == qulp_pkg::OFF_MSR;
    wire hit_stat = paddr == qulp_pkg::OFF_STAT;
    wire hit_clr = paddr == qulp_pkg::OFF_CLR;
    wire hit_en = paddr == qulp_pkg::OFF_EN;
    wire hit_mode = paddr == qulp_pkg::OFF_MODE;
    wire hit = hit_txd | hit_mcr | hit_efr | hit_ier | hit_msr |
        hit_stat | hit_clr | hit_en | hit_mode;

    // zero wait states; read data captured in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;

    // ************************************************
    // registers
    // ************************************************
    qulp_pkg::qulp_ctl_t ctl_r [NCH];
    qulp_pkg::qulp_ctl_t ctl_nxt [NCH];
    logic [EW-1:0] stat_r, en_r, ev;
    logic [31:0] prdata_r, rd_nxt;
    logic [NCH-1:0] tx_load, pend, busy, done, tx_line, rx_line;
    logic [NCH-1:0] mcr0_v, mcr1_v, mcr3_v, efr6_v, chan_irq;
    logic [NCH-1:0] rts_nxt, dtr_nxt, iout_nxt, ioe_nxt;
    logic [NCH-1:0] rts_r, dtr_r, iout_r, ioe_r;
    logic irq_r;

    // set wins over a clear in the same cycle
    wire [EW-1:0] clr_v = (apb_wr && hit_clr) ? pwdata[EW-1:0] : '0;
    wire [EW-1:0] stat_nxt = (stat_r & ~clr_v) | ev;
    wire [EW-1:0] en_nxt = (apb_wr && hit_en) ? pwdata[EW-1:0] : en_r;
    wire irq_any = |(stat_r & en_r);

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            ctl_nxt[c] = ctl_r[c];
            if (apb_wr && int'(ch_a) == c) begin
                if (hit_mcr) begin
                    ctl_nxt[c].modem_control_reg = pwdata[7:0];
                end else if (hit_efr) begin
                    ctl_nxt[c].enhanced_feature_reg = pwdata[7:0];
                end else if (hit_ier) begin
                    ctl_nxt[c].irq_enable_reg = pwdata[7:0];
                end
            end
        end
    end

    always_comb begin
        rd_nxt = '0;
        if (hit_mcr) begin
            rd_nxt[7:0] = ctl_r[ch_a].modem_control_reg;
        end else if (hit_efr) begin
            rd_nxt[7:0] = ctl_r[ch_a].enhanced_feature_reg;
        end else if (hit_ier) begin
            rd_nxt[7:0] = ctl_r[ch_a].irq_enable_reg;
        end else if (hit_msr) begin
            rd_nxt[4:0] = {busy[ch_a], pend[ch_a], rx_line[ch_a],
                ~dsr_s[ch_a], ~cts_s[ch_a]};
        end else if (hit_stat) begin
            rd_nxt[EW-1:0] = stat_r;
        end else if (hit_en) begin
            rd_nxt[EW-1:0] = en_r;
        end else if (hit_mode) begin
            rd_nxt[1:0] = {sel_s, mode_s};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int c = 0; c < NCH; c++) begin
                ctl_r[c] <= {qulp_pkg::IER_RST, qulp_pkg::EFR_RST,
                    qulp_pkg::MCR_RST};
            end
            stat_r <= '0;
            en_r <= '0;
            prdata_r <= '0;
        end else begin
            ctl_r <= ctl_nxt;
            stat_r <= stat_nxt;
            en_r <= en_nxt;
            prdata_r <= apb_set ? rd_nxt : prdata_r;
        end
    end

    assign prdata = prdata_r;

    // ************************************************
    // channels
    // ************************************************
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        assign tx_load[c] = apb_wr && hit_txd && int'(ch_a) == c;
        assign mcr0_v[c] = ctl_r[c].modem_control_reg[qulp_pkg::MCR_DTR];
        assign mcr1_v[c] = ctl_r[c].modem_control_reg[qulp_pkg::MCR_RTS];
        assign mcr3_v[c] = ctl_r[c].modem_control_reg[qulp_pkg::MCR_IRQ];
        assign efr6_v[c] = ctl_r[c].enhanced_feature_reg[qulp_pkg::EFR_ARTS];

        qulp_chan #(.BIT_CYC(BIT_CYC)) u_chan (
            .pclk(pclk),
            .presetn(presetn),
            .tx_byte(pwdata[7:0]),
            .tx_load(tx_load[c]),
            .ir_mode(ctl_r[c].modem_control_reg[qulp_pkg::MCR_IR]),
            .auto_cts(ctl_r[c].enhanced_feature_reg[qulp_pkg::EFR_ACTS]),
            .cts_n_s(cts_s[c]),
            .pend(pend[c]),
            .busy(busy[c]),
            .done(done[c]),
            .tx_out(tx_line[c])
        );

        // infrared receive: high pulse marks a zero
        assign rx_line[c] = ctl_r[c].modem_control_reg[qulp_pkg::MCR_IR] ?
            ~rx_s[c] : rx_s[c];

        // clear-to-send change irq gated by enable bit
        assign ev[2*c] = done[c];
        assign ev[2*c+1] = ctl_r[c].irq_enable_reg[qulp_pkg::IER_CTS] &
            (cts_s[c] ^ cts_d_r[c]);
        assign chan_irq[c] = |(stat_r[2*c+:2] & en_r[2*c+:2]);

        assign rts_nxt[c] = ~(mcr1_v[c] & ~(efr6_v[c] & chan_rx_stop[c]));
        assign dtr_nxt[c] = ~mcr0_v[c];
        assign iout_nxt[c] = mode_s & chan_irq[c];
        assign ioe_nxt[c] = mode_s ? (sel_s | mcr3_v[c]) :
            (c == 0 ? irq_any : 1'b1);
    end

    // ************************************************
    // pin registers
    // ************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rts_r <= '1;
            dtr_r <= '1;
            iout_r <= '0;
            ioe_r <= '0;
            irq_r <= 1'b0;
        end else begin
            rts_r <= rts_nxt;
            dtr_r <= dtr_nxt;
            iout_r <= iout_nxt;
            ioe_r <= ioe_nxt;
            irq_r <= irq_any;
        end
    end

    assign chan_serial_out = tx_line;
    assign chan_request_send_n = rts_r;
    assign chan_terminal_ready_n = dtr_r;
    assign chan_irq_out = iout_r;
    assign chan_irq_oe = ioe_r;
    assign irq = irq_r;

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence cts_edge0;
        $changed(cts_s[0]) ##0 ctl_r[0].irq_enable_reg[qulp_pkg::IER_CTS];
    endsequence

    sequence mcr_wr0;
        apb_wr && hit_mcr && ch_a == 2'h0;
    endsequence

    a_sel_forces_oe: assert property (
        (mode_s && sel_s) |=> &chan_irq_oe)
        else $error("irq pins not driven with select high");
    a_mcr_gates_oe: assert property (
        (mode_s && !sel_s) |=> chan_irq_oe == $past(mcr3_v))
        else $error("irq enable does not follow bit 3");
    a_tristate_dflt: assert property (
        (mode_s && !sel_s && mcr3_v == '0) |=> chan_irq_oe == '0)
        else $error("irq pins driven while disabled");
    a_rw_mode_pins: assert property (
        !mode_s |=> chan_irq_out == '0 &&
        chan_irq_oe[NCH-1:1] == '1 && chan_irq_oe[0] == $past(irq_any))
        else $error("read/write-select irq pins wrong");
    a_rts_gpo: assert property (
        (efr6_v == '0) |=> chan_request_send_n == ~$past(mcr1_v))
        else $error("request-to-send not general output");
    a_dtr_write: assert property (
        mcr_wr0 |=> ##1 chan_terminal_ready_n[0] == ~$past(pwdata[0], 2))
        else $error("terminal-ready does not follow write");
    a_cts_irq: assert property (
        cts_edge0 |=> stat_r[1])
        else $error("clear-to-send change not flagged");
endmodule // qulp_top

// ===== qulp_remote.sv
`timescale 1ns/100ps
// ************************************************
// far-side serial device for one channel
// ************************************************
module qulp_remote #(
    parameter int BIT_CYC = 16
) (
    input wire logic pclk,
    input wire logic ir_mode,
    input wire logic tx_line,
    output logic rx_line,
    output logic [7:0] got_byte,
    output int n_frames,
    output int n_pulses
);
    assign rx_line = ~ir_mode;
    initial begin
        got_byte = 8'h00;
        n_frames = 0;
        n_pulses = 0;
    end
    // zero bits show as high pulses in infrared mode
    always @(posedge tx_line) begin
        if (ir_mode) begin
            n_pulses++;
        end
    end
    // sample mid-bit; standard frames only
    initial begin
        forever begin
            @(negedge tx_line);
            if (!ir_mode) begin
                repeat (BIT_CYC + BIT_CYC / 2) @(posedge pclk);
                for (int i = 0; i < 8; i++) begin
                    got_byte[i] = tx_line;
                    repeat (BIT_CYC) @(posedge pclk);
                end
                n_frames++;
            end
        end
    end
endmodule // qulp_remote

// ===== qulp_top_tb_top.sv
`timescale 1ns/100ps
module qulp_top_tb_top;
    localparam int BC = 16;
    localparam int FR = qulp_pkg::FRAME_BITS * BC + 20;
    typedef struct packed {
        logic sel;
        logic [7:0] modem_control_reg;
        logic [2:0] exp;
    } qulp_row_t;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, irq, ir0, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic bus_mode_sel, irq_output_select;
    logic [2:0] sin_hi;
    logic [3:0] sout, cts_n, rts_n, dsr_n, dtr_n, rx_stop, iout, ioe;
    wire rx0;
    wire [7:0] rx_byte;
    int n_frames, n_pulses, f0, miscompares, n_checks, cyc;
    qulp_row_t rows [5] = '{
        '{1'b0, 8'h00, 3'b110},
        '{1'b0, 8'h08, 3'b111},
        '{1'b1, 8'h00, 3'b111},
        '{1'b0, 8'h03, 3'b000},
        '{1'b1, 8'h0B, 3'b001}};
    always #2.5 pclk = ~pclk;
    qulp_top #(.NCH(4), .BIT_CYC(BC)) uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .bus_mode_sel(bus_mode_sel),
        .irq_output_select(irq_output_select),
        .chan_serial_in({sin_hi, rx0}), .chan_serial_out(sout),
        .chan_clear_send_n(cts_n), .chan_request_send_n(rts_n),
        .chan_set_ready_n(dsr_n), .chan_terminal_ready_n(dtr_n),
        .chan_rx_stop(rx_stop), .chan_irq_out(iout), .chan_irq_oe(ioe));
    qulp_remote #(.BIT_CYC(BC)) far (.pclk(pclk), .ir_mode(ir0),
        .tx_line(sout[0]), .rx_line(rx0), .got_byte(rx_byte),
        .n_frames(n_frames), .n_pulses(n_pulses));
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task results;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // one apb transfer; holds until pready seen high
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_c(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            results();
        end
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn, ir0} = '0;
        {miscompares, n_checks, cyc} = '0;
        {bus_mode_sel, irq_output_select, sin_hi} = 5'b10111;
        {cts_n, dsr_n, rx_stop} = 12'h0F0;
        wait_c(11);
        chk("tx_rst", 4'hF, sout);
        chk("oe_rst", 4'h0, ioe);
        chk("pins_rst", 9'h1FE, {rts_n, dtr_n, irq});
        @(posedge pclk);
        presetn <= 1'b1;
        wait_c(4);
        apb(0, 8'h8C, 0);
        chk("mode", 32'h1, rd);
        for (int i = 0; i < 5; i++) begin
            @(posedge pclk);
            irq_output_select <= rows[i].sel;
            apb(1, 8'h04, {24'h0, rows[i].modem_control_reg});
            wait_c(4);
            chk("pins", rows[i].exp, {rts_n[0], dtr_n[0], ioe[0]});
        end
        f0 = n_frames;
        apb(1, 8'h00, 32'hA5);
        wait_c(FR);
        chk("frame", {f0 + 1, 8'hA5}, {n_frames, rx_byte});
        chk("idle_hi", 1'b1, sout[0]);
        apb(1, 8'h08, 32'h80);
        apb(1, 8'h0C, 32'h80);
        apb(1, 8'h84, 32'hFF);
        apb(1, 8'h88, 32'h2);
        wait_c(3);
        chk("irq_mask", 1'b0, irq);
        apb(1, 8'h00, 32'h3C);
        apb(1, 8'h00, 32'h5A);
        wait_c(BC * 4);
        @(posedge pclk);
        cts_n[0] <= 1'b1;
        wait_c(FR);
        chk("cts_fin", {f0 + 2, 8'h3C}, {n_frames, rx_byte});
        wait_c(BC * 4);
        chk("cts_hold", 1'b1, sout[0]);
        apb(0, 8'h10, 0);
        chk("pending", 1'b1, rd[3]);
        chk("irq_cts", 2'b11, {irq, iout[0]});
        apb(1, 8'h84, 32'h2);
        wait_c(3);
        chk("irq_clr", 1'b0, irq);
        @(posedge pclk);
        cts_n[0] <= 1'b0;
        wait_c(FR);
        chk("cts_go", {f0 + 3, 8'h5A}, {n_frames, rx_byte});
        ir0 <= 1'b1;
        apb(1, 8'h04, 32'h40);
        wait_c(4);
        chk("ir_idle", 1'b0, sout[0]);
        f0 = n_pulses;
        apb(1, 8'h00, 32'hA5);
        wait_c(FR);
        chk("ir_pulses", 5, n_pulses - f0);
        chk("ir_end", 1'b0, sout[0]);
        ir0 <= 1'b0;
        apb(1, 8'h04, 32'h02);
        apb(1, 8'h08, 32'h40);
        rx_stop[0] <= 1'b1;
        wait_c(4);
        chk("rts_auto", 1'b1, rts_n[0]);
        @(posedge pclk);
        rx_stop[0] <= 1'b0;
        dsr_n[0] <= 1'b0;
        wait_c(4);
        chk("rts_gp", 1'b0, rts_n[0]);
        apb(0, 8'h10, 0);
        chk("dsr", 2'b11, {rd[1], sout[0]});
        apb(0, 8'h90, 0);
        chk("unmapped", 33'h100000000, {err, rd});
        irq_output_select <= 1'b0;
        bus_mode_sel <= 1'b0;
        wait_c(5);
        chk("mode_lo", 6'h38, {ioe[3:1], iout[3:1]});
        apb(0, 8'h8C, 0);
        chk("mode_rd", 32'h0, rd);
        results();
    end
endmodule // qulp_top_tb_top
